// >>> logic/clock_domain_ctl.sv
// Operation
// - Divider ratios follow automatically from frequency codes and sample-rate selectors.
// - Each domain takes its source from a selector; a chosen loop must run.
// - Core rate of each domain never exceeds its configured clock frequency.
// - With the rate limit bit clear, core rate caps at code 2.
// - Main sample-rate selectors accept every rate from 8kHz to 192kHz.
// - Each domain shows an off status and an event when shutdown completes.
// - Each domain's off status is driven directly onto a pin.
// - Path enables are checked against domain capacity and refused when short.
// - A refused request leaves running paths that it still requests running.
// - Underclocked is flagged when a faster domain clock would fit the request.
// - Overclocked is flagged when the request exceeds the device limit.
// - Underclocked and overclocked conditions appear on pins for interrupts and GPIOs.
// - Frequency codes 0 to 3 double the rate each step; others are reserved.
// - Sample-rate codes 01h-05h, 09h-0Dh, 11h-13h; 00h means none.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/10ps
module clock_domain_ctl
  import clock_domain_pkg::*;
#(
  parameter int NUM_PATHS = 8,
  parameter int PATH_COST = 2
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register port.
  input wire logic [15:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  // Clock source selection.
  output logic [3:0] main_src_sel,
  output logic [3:0] sec_src_sel,
  // Core rates and divider ratios.
  output dom_rate_t main_rate,
  output dom_rate_t sec_rate,
  output logic [2:0][15:0] main_ratio,
  output logic [2:0][15:0] sec_ratio,
  // Signal paths.
  output logic [NUM_PATHS-1:0] path_active,
  // Status pins and interrupt sources.
  output logic main_off_pin,
  output logic sec_off_pin,
  output logic main_off_evt,
  output logic sec_off_evt,
  output clk_err_t err_pin
);

  if (NUM_PATHS < 1 || NUM_PATHS > 16)
    $error("NUM_PATHS must lie between 1 and 16");
  if (PATH_COST < 1 || PATH_COST > 8)
    $error("PATH_COST must lie between 1 and 8");

  typedef struct packed {
    dom_cfg_t main_cfg;
    dom_cfg_t sec_cfg;
    logic [2:0][4:0] main_sr;
    logic [2:0][4:0] sec_sr;
    logic limit;
    shut_t main_sd;
    shut_t sec_sd;
    clk_err_t err;
    logic [NUM_PATHS-1:0] active;
    logic [NUM_PATHS-1:0] domain;
    logic [15:0] rdata;
  } st_t;

  st_t st_q;
  st_t st_d;
  logic sec_family;
  logic path_wr;
  logic [1:0] refuse;
  logic [1:0][7:0] need;
  logic [1:0][7:0] limit_units;
  logic [7:0] main_load;

  // Number of set bits in a path vector.
  function automatic logic [4:0] popcount(input logic [15:0] v);
    popcount = 5'h00;
    for (int i = 0; i < 16; i++)
      popcount = popcount + 5'(v[i]);
  endfunction

  // Load in capacity units of a set of paths.
  function automatic logic [7:0] load_of(input logic [NUM_PATHS-1:0] v);
    load_of = 8'(popcount(16'(v)) * 8'(PATH_COST));
  endfunction

  // Capacity units of a fully running domain at a frequency code.
  function automatic logic [7:0] units_of(input logic [2:0] code);
    units_of = 8'(8'h01 << code);
  endfunction

  // One step of a domain's shutdown handshake.
  function automatic shut_t shut_step(input shut_t s, input logic was_on, input logic now_on);
    shut_t r;
    r = s;
    r.evt = 1'b0;
    if (was_on && !now_on)
    begin
      r.stop = 1'b1;
      r.cnt = SHUT_CNT_INIT;
      r.off = 1'b0;
    end
    else if (now_on)
    begin
      r.stop = 1'b0;
      r.off = 1'b0;
    end
    else if (s.stop)
    begin
      if (s.cnt == 8'h00)
      begin
        r.stop = 1'b0;
        r.off = 1'b1;
        r.evt = 1'b1;
      end
      else
        r.cnt = s.cnt - 8'h01;
    end
    shut_step = r;
  endfunction

  // Fields of a domain control register.
  function automatic logic [15:0] cfg_word(input dom_cfg_t c);
    cfg_word = 16'h0000;
    cfg_word[FAMILY_POS] = c.family;
    cfg_word[FREQ_POS +: 3] = c.freq;
    cfg_word[ENA_POS] = c.ena;
    cfg_word[SRC_POS +: 4] = c.src;
  endfunction

  function automatic dom_cfg_t cfg_field(input logic [15:0] w, input logic with_family);
    dom_cfg_t c;
    c.family = with_family & w[FAMILY_POS];
    c.freq = w[FREQ_POS +: 3];
    c.ena = w[ENA_POS];
    c.src = w[SRC_POS +: 4];
    cfg_field = c;
  endfunction

  // The secondary family follows its selectors: codes 09h to 0Dh mark 44.1kHz.
  assign sec_family = st_q.sec_sr[0][3] | st_q.sec_sr[1][3] | st_q.sec_sr[2][3];
  assign path_wr = wr_en && addr == PATH_REQ_OFS;
  assign main_load = load_of(st_q.active & ~st_q.domain);

  rate_ratio_calc main_calc (
    .clk(clk),
    .srst(srst),
    .cfg(st_q.main_cfg),
    .family(st_q.main_cfg.family),
    .limit(st_q.limit),
    .sr(st_q.main_sr),
    .rate(main_rate),
    .ratio(main_ratio)
  );

  rate_ratio_calc sec_calc (
    .clk(clk),
    .srst(srst),
    .cfg(st_q.sec_cfg),
    .family(sec_family),
    .limit(st_q.limit),
    .sr(st_q.sec_sr),
    .rate(sec_rate),
    .ratio(sec_ratio)
  );

  always_comb
  begin
    logic [NUM_PATHS-1:0] req;
    logic [NUM_PATHS-1:0] keep;
    logic [NUM_PATHS-1:0] newbits;
    logic [NUM_PATHS-1:0] mask;
    logic [NUM_PATHS-1:0] granted;
    logic [3:0] cap;
    logic [15:0] rmux;
    req = wr_data[NUM_PATHS-1:0];
    keep = st_q.active & req;
    newbits = '0;
    mask = '0;
    granted = '0;
    cap = 4'h0;
    rmux = 16'h0000;
    refuse = 2'b00;
    need = '0;
    limit_units = '0;
    st_d = st_q;

    if (wr_en)
    begin
      case (addr)
        MAIN_CLK_OFS: st_d.main_cfg = cfg_field(wr_data, 1'b1);
        SEC_CLK_OFS: st_d.sec_cfg = cfg_field(wr_data, 1'b0);
        CORE_CFG_OFS: st_d.limit = wr_data[LIMIT_POS];
        PATH_DOM_OFS: st_d.domain = wr_data[NUM_PATHS-1:0];
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (addr == MAIN_SR_OFS + 16'(i))
              st_d.main_sr[i] = wr_data[4:0];
            if (addr == SEC_SR_OFS + 16'(i))
              st_d.sec_sr[i] = wr_data[4:0];
          end
        end
      endcase
    end

    // Disables take effect at once; each domain admits its new paths only as a whole.
    if (path_wr)
    begin
      granted = keep;
      for (int d = 0; d < 2; d++)
      begin
        mask = (d == 0) ? ~st_q.domain : st_q.domain;
        cap = (d == 0) ? main_rate.capacity : sec_rate.capacity;
        newbits = req & ~st_q.active & mask;
        need[d] = load_of((keep | newbits) & mask);
        limit_units[d] = units_of(st_q.limit ? MAX_FREQ_CODE : CAP_FREQ_CODE);
        if (newbits != '0)
        begin
          if (need[d] <= 8'(cap))
            granted = granted | newbits;
          else
            refuse[d] = 1'b1;
        end
      end
      st_d.active = granted;
    end

    // Hardware sets win over a clear in the same cycle.
    if (wr_en && addr == CLK_STS_OFS)
      st_d.err = st_q.err & ~clk_err_t'(wr_data[ERR_POS +: 3]);
    if (refuse[0] && need[0] <= limit_units[0])
      st_d.err.main_under = 1'b1;
    if (refuse[1] && need[1] <= limit_units[1])
      st_d.err.sec_under = 1'b1;
    if ((refuse[0] && need[0] > limit_units[0]) || (refuse[1] && need[1] > limit_units[1]))
      st_d.err.over = 1'b1;

    st_d.main_sd = shut_step(st_q.main_sd, st_q.main_cfg.ena, st_d.main_cfg.ena);
    st_d.sec_sd = shut_step(st_q.sec_sd, st_q.sec_cfg.ena, st_d.sec_cfg.ena);
    if (st_q.main_sd.stop)
      st_d.active = st_d.active & st_q.domain;
    if (st_q.sec_sd.stop)
      st_d.active = st_d.active & ~st_q.domain;

    case (addr)
      MAIN_CLK_OFS: rmux = cfg_word(st_q.main_cfg);
      SEC_CLK_OFS: rmux = cfg_word(st_q.sec_cfg);
      CORE_CFG_OFS: rmux[LIMIT_POS] = st_q.limit;
      CLK_STS_OFS:
      begin
        rmux[MAIN_OFF_POS] = st_q.main_sd.off;
        rmux[SEC_OFF_POS] = st_q.sec_sd.off;
        rmux[ERR_POS +: 3] = st_q.err;
      end
      PATH_REQ_OFS, PATH_ACT_OFS: rmux[NUM_PATHS-1:0] = st_q.active;
      PATH_DOM_OFS: rmux[NUM_PATHS-1:0] = st_q.domain;
      CORE_RATE_OFS:
      begin
        rmux[2:0] = main_rate.eff_code;
        rmux[SEC_RATE_POS +: 3] = sec_rate.eff_code;
      end
      default:
      begin
        for (int i = 0; i < 3; i++)
        begin
          if (addr == MAIN_SR_OFS + 16'(i))
            rmux[4:0] = st_q.main_sr[i];
          if (addr == SEC_SR_OFS + 16'(i))
            rmux[4:0] = st_q.sec_sr[i];
          // Status shows a selection only while its domain runs and the code suits the family.
          if (addr == MAIN_STS_OFS + 16'(i) && st_q.main_cfg.ena && main_rate.sr_ok[i])
            rmux[4:0] = st_q.main_sr[i];
          if (addr == SEC_STS_OFS + 16'(i) && st_q.sec_cfg.ena && sec_rate.sr_ok[i])
            rmux[4:0] = st_q.sec_sr[i];
        end
      end
    endcase
    st_d.rdata = rd_en ? rmux : 16'h0000;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_q <= '0;
      st_q.main_cfg.freq <= FREQ_RST;
      st_q.main_cfg.src <= SRC_RST;
      st_q.sec_cfg.freq <= FREQ_RST;
      st_q.sec_cfg.src <= SRC_RST;
      st_q.main_sr <= {3{SR_RST}};
      st_q.sec_sr <= {3{SR_RST}};
      st_q.main_sd.off <= 1'b1;
      st_q.sec_sd.off <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign rd_data = st_q.rdata;
  assign main_src_sel = st_q.main_cfg.src;
  assign sec_src_sel = st_q.sec_cfg.src;
  assign path_active = st_q.active;
  assign main_off_pin = st_q.main_sd.off;
  assign sec_off_pin = st_q.sec_sd.off;
  assign main_off_evt = st_q.main_sd.evt;
  assign sec_off_evt = st_q.sec_sd.evt;
  assign err_pin = st_q.err;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_rate_capped: assert property (!st_q.limit [*2] |-> main_rate.eff_code <= 3'h2 && sec_rate.eff_code <= 3'h2)
    else $error("core rate above cap while limit bit clear");
  a_rate_bounded: assert property ($past(st_q.main_cfg.freq) <= 3'h3 |->
    main_rate.eff_code <= $past(st_q.main_cfg.freq))
    else $error("main core rate above configured frequency");
  a_ratio_eight_k: assert property (!$past(srst) && $past(st_q.main_sr[0]) == 5'h11 &&
    !$past(st_q.main_cfg.family) |-> main_ratio[0] == 16'(16'h0300 << main_rate.eff_code))
    else $error("wrong divider ratio for 8kHz");
  a_source_follows: assert property (wr_en && addr == MAIN_CLK_OFS |=> main_src_sel == $past(wr_data[3:0]))
    else $error("main source select not taken");
  a_shutdown_done: assert property ($fell(st_q.main_cfg.ena) && !main_off_pin |->
    !main_off_pin ##[1:20] main_off_pin)
    else $error("main shutdown did not complete");
  a_off_event: assert property (main_off_evt == $rose(main_off_pin))
    else $error("main off event not tied to status rise");
  a_load_fits: assert property (path_wr && !refuse[0] && !st_q.main_sd.stop |=>
    main_load <= 8'($past(main_rate.capacity)) || $past(main_load) == main_load)
    else $error("main domain admitted beyond capacity");
  a_refuse_keeps: assert property (path_wr && refuse[0] && !st_q.main_sd.stop && !st_q.sec_sd.stop |=>
    (path_active & $past(path_active & wr_data[NUM_PATHS-1:0])) == $past(path_active & wr_data[NUM_PATHS-1:0]))
    else $error("refused request stopped a running path");
  a_under_flag: assert property (path_wr && refuse[0] && need[0] <= limit_units[0] |=> err_pin.main_under)
    else $error("main underclock not flagged");
  a_over_flag: assert property (path_wr && refuse[0] && need[0] > limit_units[0] |=>
    err_pin.over && err_pin.main_under == $past(err_pin.main_under))
    else $error("overclock not flagged");
  a_error_sticky: assert property (err_pin.main_under && !(wr_en && addr == CLK_STS_OFS && wr_data[ERR_POS]) |=>
    err_pin.main_under)
    else $error("underclock flag dropped without clear");

  c_refused: cover property (path_wr && refuse[0]);
  c_shutdown: cover property ($rose(main_off_pin));
  c_overclock: cover property ($rose(err_pin.over));

endmodule

// >>> logic/clock_domain_pkg.sv
package clock_domain_pkg;

  // Register offsets.
  localparam logic [15:0] MAIN_CLK_OFS = 16'h0101;
  localparam logic [15:0] MAIN_SR_OFS = 16'h0102;
  localparam logic [15:0] MAIN_STS_OFS = 16'h010A;
  localparam logic [15:0] SEC_CLK_OFS = 16'h0112;
  localparam logic [15:0] SEC_SR_OFS = 16'h0113;
  localparam logic [15:0] SEC_STS_OFS = 16'h011B;
  localparam logic [15:0] CORE_CFG_OFS = 16'h0120;
  localparam logic [15:0] CLK_STS_OFS = 16'h0121;
  localparam logic [15:0] PATH_REQ_OFS = 16'h0122;
  localparam logic [15:0] PATH_DOM_OFS = 16'h0123;
  localparam logic [15:0] PATH_ACT_OFS = 16'h0124;
  localparam logic [15:0] CORE_RATE_OFS = 16'h0125;

  // Field positions.
  localparam int FAMILY_POS = 15;
  localparam int FREQ_POS = 8;
  localparam int ENA_POS = 6;
  localparam int SRC_POS = 0;
  localparam int LIMIT_POS = 0;
  localparam int MAIN_OFF_POS = 0;
  localparam int SEC_OFF_POS = 1;
  localparam int ERR_POS = 2;
  localparam int SEC_RATE_POS = 4;

  // Values after reset.
  localparam logic [2:0] FREQ_RST = 3'h3;
  localparam logic [3:0] SRC_RST = 4'h4;
  localparam logic [4:0] SR_RST = 5'h11;

  // Frequency codes: 3 is the top code, 2 is the capped core rate.
  localparam logic [2:0] MAX_FREQ_CODE = 3'h3;
  localparam logic [2:0] CAP_FREQ_CODE = 3'h2;

  // Cycles from a clock disable to the off status.
  localparam int SHUTDOWN_CYCLES = 16;
  localparam logic [7:0] SHUT_CNT_INIT = 8'(SHUTDOWN_CYCLES - 1);

  typedef struct packed {
    logic family;
    logic [2:0] freq;
    logic ena;
    logic [3:0] src;
  } dom_cfg_t;

  typedef struct packed {
    logic over;
    logic sec_under;
    logic main_under;
  } clk_err_t;

  typedef struct packed {
    logic [2:0] eff_code;
    logic [3:0] capacity;
    logic [2:0] sr_ok;
  } dom_rate_t;

  typedef struct packed {
    logic stop;
    logic off;
    logic evt;
    logic [7:0] cnt;
  } shut_t;

endpackage

// >>> logic/rate_ratio_calc.sv
`timescale 1ns/10ps
module rate_ratio_calc
  import clock_domain_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Domain settings.
  input dom_cfg_t cfg,
  input wire logic family,
  input wire logic limit,
  input wire logic [2:0][4:0] sr,
  // Derived rates.
  output dom_rate_t rate,
  output logic [2:0][15:0] ratio
);

  typedef struct packed {
    dom_rate_t rate;
    logic [2:0][15:0] ratio;
  } calc_st_t;

  calc_st_t st_q;
  calc_st_t st_d;

  // Core cycles per sample at the lowest frequency code; zero means no rate.
  function automatic logic [15:0] base_ratio(input logic [4:0] code);
    case (code)
      5'h01, 5'h09: base_ratio = 16'h0200;
      5'h02, 5'h0A: base_ratio = 16'h0100;
      5'h03, 5'h0B: base_ratio = 16'h0080;
      5'h04, 5'h0C: base_ratio = 16'h0040;
      5'h05, 5'h0D: base_ratio = 16'h0020;
      5'h11: base_ratio = 16'h0300;
      5'h12: base_ratio = 16'h0180;
      5'h13: base_ratio = 16'h00C0;
      default: base_ratio = 16'h0000;
    endcase
  endfunction

  always_comb
  begin
    st_d = st_q;
    if (cfg.freq > MAX_FREQ_CODE)
      st_d.rate.eff_code = 3'h0;
    else if (!limit && cfg.freq > CAP_FREQ_CODE)
      st_d.rate.eff_code = CAP_FREQ_CODE;
    else
      st_d.rate.eff_code = cfg.freq;
    st_d.rate.capacity = (cfg.ena && cfg.freq <= MAX_FREQ_CODE) ? 4'(4'h1 << st_d.rate.eff_code) : 4'h0;
    for (int i = 0; i < 3; i++)
    begin
      st_d.rate.sr_ok[i] = (base_ratio(sr[i]) != 16'h0000) && (sr[i][3] == family);
      st_d.ratio[i] = st_d.rate.sr_ok[i] ? 16'(base_ratio(sr[i]) << st_d.rate.eff_code) : 16'h0000;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign rate = st_q.rate;
  assign ratio = st_q.ratio;

endmodule

// >>> verification/test_audio_core_clock_domain_control.sv
`timescale 1ns/10ps
module test_audio_core_clock_domain_control
  import clock_domain_pkg::*;
;
  localparam int NP = 8;
  logic clk;
  logic srst;
  logic [15:0] addr;
  logic [15:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [15:0] rd_data;
  logic [3:0] main_src_sel;
  logic [3:0] sec_src_sel;
  dom_rate_t main_rate;
  dom_rate_t sec_rate;
  logic [2:0][15:0] main_ratio;
  logic [2:0][15:0] sec_ratio;
  logic [NP-1:0] path_active;
  logic main_off_pin;
  logic sec_off_pin;
  logic main_off_evt;
  logic sec_off_evt;
  clk_err_t err_pin;
  int n_errors;
  int tests_run;

  clock_domain_ctl #(.NUM_PATHS(NP), .PATH_COST(2)) u_clock_domain_ctl (
    .clk(clk), .srst(srst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .main_src_sel(main_src_sel), .sec_src_sel(sec_src_sel),
    .main_rate(main_rate), .sec_rate(sec_rate), .main_ratio(main_ratio), .sec_ratio(sec_ratio),
    .path_active(path_active), .main_off_pin(main_off_pin), .sec_off_pin(sec_off_pin),
    .main_off_evt(main_off_evt), .sec_off_evt(sec_off_evt), .err_pin(err_pin)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Values straight after reset, including an unmapped address.
  task automatic t_reset_values;
    settle();
    rd_chk(16'h0101, 16'h0304);
    rd_chk(16'h0102, 16'h0011);
    rd_chk(16'h0112, 16'h0304);
    rd_chk(16'h0121, 16'h0003);
    rd_chk(16'h010A, 16'h0000);
    rd_chk(16'h0200, 16'h0000);
    check({15'h0, main_off_pin}, 16'h0001);
    check({15'h0, sec_off_pin}, 16'h0001);
    check({13'h0, err_pin}, 16'h0000);
    check({12'h0, main_src_sel}, 16'h0004);
  endtask

  // Every documented selector code of both families, a wrong-family code and a read-only write.
  task automatic t_sample_rates;
    logic [4:0] fam0 [8];
    logic [4:0] fam1 [5];
    fam0 = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h11, 5'h12, 5'h13};
    fam1 = '{5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D};
    wr(16'h0101, 16'h0340);
    settle();
    check({12'h0, main_src_sel}, 16'h0000);
    check({15'h0, main_off_pin}, 16'h0000);
    foreach (fam0[i])
    begin
      wr(16'h0102, {11'h0, fam0[i]});
      rd_chk(16'h010A, {11'h0, fam0[i]});
    end
    settle();
    check(main_ratio[0], 16'h0300);
    wr(16'h0102, 16'h0009);
    rd_chk(16'h010A, 16'h0000);
    settle();
    check(main_ratio[0], 16'h0000);
    wr(16'h0101, 16'h8340);
    foreach (fam1[i])
    begin
      wr(16'h0102, {11'h0, fam1[i]});
      rd_chk(16'h010A, {11'h0, fam1[i]});
    end
    wr(16'h010A, 16'h1234);
    rd_chk(16'h010A, 16'h000D);
    wr(16'h0101, 16'h0340);
    wr(16'h0102, 16'h0003);
  endtask

  // Core rate follows the frequency code and the rate limit bit.
  task automatic t_core_rate;
    rd_chk(16'h0125, 16'h0022);
    wr(16'h0120, 16'h0001);
    rd_chk(16'h0125, 16'h0033);
    check({13'h0, main_rate.eff_code}, 16'h0003);
    wr(16'h0120, 16'h0000);
    wr(16'h0101, 16'h0140);
    rd_chk(16'h0125, 16'h0021);
    wr(16'h0101, 16'h0340);
  endtask

  task automatic req_chk(input logic [15:0] req, input logic [7:0] act, input logic [2:0] err);
    wr(16'h0122, req);
    settle();
    check({8'h0, path_active}, {8'h0, act});
    check({13'h0, err_pin}, {13'h0, err});
  endtask

  // Accepted, overclocked, underclocked and secondary requests; running paths survive refusals.
  task automatic t_path_check;
    wr(16'h0123, 16'h0080);
    req_chk(16'h0003, 8'h03, 3'h0);
    req_chk(16'h0007, 8'h03, 3'h4);
    wr(16'h0121, 16'h001C);
    settle();
    check({13'h0, err_pin}, 16'h0000);
    wr(16'h0101, 16'h0140);
    req_chk(16'h0001, 8'h01, 3'h0);
    req_chk(16'h0003, 8'h01, 3'h1);
    rd_chk(16'h0121, 16'h0006);
    req_chk(16'h0081, 8'h01, 3'h3);
    wr(16'h0121, 16'h001C);
    wr(16'h0101, 16'h0340);
    wr(16'h0113, 16'h0003);
    wr(16'h0112, 16'h0348);
    settle();
    check({12'h0, sec_src_sel}, 16'h0008);
    check(sec_ratio[0], 16'h0200);
    rd_chk(16'h011B, 16'h0003);
    check({15'h0, sec_off_pin}, 16'h0000);
    req_chk(16'h0081, 8'h81, 3'h0);
    req_chk(16'h0000, 8'h00, 3'h0);
  endtask

  // Clears one domain enable and times the off status and its event.
  task automatic t_shutdown(input logic [15:0] ofs, input logic [15:0] val, input logic sec);
    int n;
    wr(ofs, val);
    for (n = 1; n <= 40; n++)
    begin
      @(posedge clk);
      #1;
      if (sec ? sec_off_pin : main_off_pin)
      begin
        break;
      end
    end
    if (n > 40)
    begin
      n_errors++;
      $display("Error at %0t: off status never rose", $time);
      stop_test();
    end
    check(16'(n), 16'(SHUTDOWN_CYCLES));
    check({15'h0, (sec ? sec_off_evt : main_off_evt)}, 16'h0001);
    @(posedge clk);
    #1;
    check({15'h0, (sec ? sec_off_evt : main_off_evt)}, 16'h0000);
    check({15'h0, (sec ? sec_off_pin : main_off_pin)}, 16'h0001);
  endtask

  initial
  begin
    srst = 1'b1;
    addr = 16'h0000;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_errors = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_reset_values();
    t_sample_rates();
    t_core_rate();
    t_path_check();
    t_shutdown(16'h0112, 16'h0308, 1'b1);
    t_shutdown(16'h0101, 16'h0300, 1'b0);
    rd_chk(16'h0121, 16'h0003);
    stop_test();
  end
endmodule
